//--- hw/alu_flag_calc.sv
`timescale 1ns/1ns
// combinational result and flag computation for one instruction
module alu_flag_calc (
  // instruction
  input  wire status_pkg::op_e    op,
  input  wire logic [7:0]         w,
  input  wire logic [7:0]         f,
  input  wire logic [2:0]         bit_sel,
  input  wire logic               c_in,
  // outputs
  output logic [7:0]              result,
  output status_pkg::flags_s      flg,
  output status_pkg::flags_s      aff
);

  logic [8:0] sum;     // full add with carry out
  logic [4:0] nib;     // low nibble add with carry out
  logic [7:0] addend;  // second adder input

  // one adder serves add and subtract
  always_comb begin
    // subtract: operand minus w as operand + ~w + 1
    if (op == status_pkg::OP_SUB_REG || op == status_pkg::OP_SUB_IMM) begin
      addend = ~w;
      sum    = {1'b0, f} + {1'b0, addend} + 9'h001;
      nib    = {1'b0, f[3:0]} + {1'b0, addend[3:0]} + 5'h01;
    end else begin
      addend = w;
      sum    = {1'b0, f} + {1'b0, addend};
      nib    = {1'b0, f[3:0]} + {1'b0, addend[3:0]};
    end
  end

  // result, flag values and which flags the op owns
  always_comb begin
    result = f;
    flg    = '0;
    aff    = '0;
    case (op)
      status_pkg::OP_ADD_REG, status_pkg::OP_ADD_IMM,
      status_pkg::OP_SUB_REG, status_pkg::OP_SUB_IMM: begin
        result = sum[7:0];
        flg.dc = nib[4];
        flg.c  = sum[8];
        aff    = '{z: 1'b1, dc: 1'b1, c: 1'b1};
      end
      status_pkg::OP_AND: begin
        result = f & w;
        aff.z  = 1'b1;
      end
      status_pkg::OP_IOR: begin
        result = f | w;
        aff.z  = 1'b1;
      end
      status_pkg::OP_XOR: begin
        result = f ^ w;
        aff.z  = 1'b1;
      end
      status_pkg::OP_ZERO_REG: begin
        result = 8'h00;
        aff.z  = 1'b1;
      end
      status_pkg::OP_ROT_R: begin
        result = {c_in, f[7:1]};
        flg.c  = f[0];
        aff.c  = 1'b1;
      end
      status_pkg::OP_ROT_L: begin
        result = {f[6:0], c_in};
        flg.c  = f[7];
        aff.c  = 1'b1;
      end
      status_pkg::OP_BIT_CLR: result = f & ~(8'h01 << bit_sel);
      status_pkg::OP_BIT_SET: result = f | (8'h01 << bit_sel);
      status_pkg::OP_SWAP:    result = {f[3:0], f[7:4]};
      status_pkg::OP_MOVE_W:  result = w;
      default:                result = f;
    endcase
    // zero test on the final result
    flg.z = (result == 8'h00);
  end

endmodule // alu_flag_calc

//--- hw/alu_status_flags.sv
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ns
// status flag register of the core with apb view and event interrupt
module alu_status_flags #(
  parameter int ADDR_W = 16  // apb byte address width
) (
  // clock, reset, enable
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               ce,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // execution datapath
  input  wire status_pkg::exec_s  exec,
  output logic [7:0]              result,
  output logic                    result_valid,
  output logic [7:0]              status,
  // hardware events
  input  wire logic               wdt_timeout,
  input  wire logic               warm_reset,
  input  wire logic               warm_reset_wdt,
  // interrupt
  output logic                    irq
);

  // ---------------------------------------------------------------
  // flag computation
  // ---------------------------------------------------------------
  logic [7:0]         status_r; // status flags, bits 4..0 used
  logic [7:0]         alu_res;  // computed result
  status_pkg::flags_s alu_flg;  // computed flags
  status_pkg::flags_s alu_aff;  // flags owned by the op

  alu_flag_calc u_calc (
    .op      (exec.op),
    .w       (exec.w),
    .f       (exec.f),
    .bit_sel (exec.bit_sel),
    .c_in    (status_r[status_pkg::FLD_C]),
    .result  (alu_res),
    .flg     (alu_flg),
    .aff     (alu_aff)
  );

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic [13:0] idx;       // word index of access
  logic        hit_stat;  // status mirror in any bank
  logic        hit_istat; // interrupt status
  logic        hit_imask; // interrupt mask
  logic        hit_any;   // mapped address
  logic        setup;     // read capture pending
  logic        wr_acc;    // write takes effect now
  logic        wr_lane0;  // low byte lane enabled
  logic        armed_r;   // capture held for open transfer
  logic        armed_nxt;

  always_comb begin
    idx       = paddr[15:2];
    // every bank mirrors the status location
    hit_stat  = (idx < status_pkg::BANK_SPACE) &&
                status_pkg::is_status_loc(idx[11:0]);
    hit_istat = (idx == status_pkg::IRQ_STAT_IDX);
    hit_imask = (idx == status_pkg::IRQ_MASK_IDX);
    hit_any   = hit_stat | hit_istat | hit_imask;
    setup     = psel & ~armed_r;
    wr_acc    = pready & psel & penable & pwrite & hit_any;
    wr_lane0  = pstrb[0];
  end

  // ---------------------------------------------------------------
  // apb transfer arming
  // ---------------------------------------------------------------
  // a setup edge spent frozen must not end the transfer with stale
  // read data, so the answer waits until a capture has been taken
  always_comb begin
    armed_nxt = armed_r;
    if (setup) begin
      // capture taken at this edge
      armed_nxt = 1'b1;
    end else if (psel && penable) begin
      // armed access completes at this edge
      armed_nxt = 1'b0;
    end else if (!psel) begin
      // idle bus, nothing pending
      armed_nxt = 1'b0;
    end
  end

  // register only, frozen with the rest of the block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_r <= 1'b0;
    end else if (ce) begin
      armed_r <= armed_nxt;
    end
  end

  // a frozen block stalls the bus rather than drop a transfer;
  // with ce high the access phase still has no wait state
  assign pready = ce & armed_r;

  // ---------------------------------------------------------------
  // status register
  // ---------------------------------------------------------------
  logic [7:0] status_nxt;
  logic       dst_stat;    // instruction writes status
  logic       blocked;     // flag write overridden by op

  // next status: instruction, then events, then reset causes
  always_comb begin
    status_nxt = status_r;
    dst_stat   = exec.valid & exec.to_file &
                 status_pkg::is_status_loc(exec.dst_addr);
    blocked    = dst_stat & (alu_aff.z | alu_aff.dc | alu_aff.c);
    // software write over apb: only arithmetic flags accepted
    if (wr_acc && hit_stat && wr_lane0) begin
      status_nxt = (status_r & ~status_pkg::STATUS_WMASK) |
                   (pwdata[7:0] & status_pkg::STATUS_WMASK);
    end
    if (exec.valid) begin
      // plain destination write, cause bits protected
      if (dst_stat) begin
        status_nxt = (status_r & ~status_pkg::STATUS_WMASK) |
                     (alu_res & status_pkg::STATUS_WMASK);
        // any owned flag disables writes to all three
        if (blocked) begin
          status_nxt[2:0] = status_r[2:0];
        end
      end
      // owned flags follow the operation unless a warm reset holds them
      if (alu_aff.z) begin
        status_nxt[status_pkg::FLD_Z] = alu_flg.z;
      end
      if (alu_aff.dc) begin
        status_nxt[status_pkg::FLD_DC] = alu_flg.dc;
      end
      if (alu_aff.c) begin
        status_nxt[status_pkg::FLD_C] = alu_flg.c;
      end
      // watchdog clear marks both cause bits
      if (exec.op == status_pkg::OP_WDT_CLR) begin
        status_nxt[status_pkg::FLD_TO] = 1'b1;
        status_nxt[status_pkg::FLD_PD] = 1'b1;
      end
      // doze: time-out bit set, sleep bit cleared
      if (exec.doze) begin
        status_nxt[status_pkg::FLD_TO] = 1'b1;
        status_nxt[status_pkg::FLD_PD] = 1'b0;
      end
    end
    // a real time-out outranks a clear in the same cycle
    if (wdt_timeout) begin
      status_nxt[status_pkg::FLD_TO] = 1'b0;
    end
    // warm reset keeps flags, cause bits from the reset source
    if (warm_reset) begin
      status_nxt[2:0] = status_r[2:0];
      if (warm_reset_wdt) begin
        status_nxt[status_pkg::FLD_TO] = 1'b0;
      end
    end
    status_nxt = status_nxt & status_pkg::STATUS_IMPL;
  end

  // power-on value loads on presetn
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= status_pkg::STATUS_RST;
    end else if (ce) begin
      status_r <= status_nxt;
    end
  end

  assign status = status_r;

  // ---------------------------------------------------------------
  // result to the datapath
  // ---------------------------------------------------------------
  logic [7:0] result_r;        // registered result
  logic [7:0] result_nxt;
  logic       result_valid_r;  // result strobe
  logic       result_valid_nxt;

  // status destination writes report what was actually stored
  always_comb begin
    result_valid_nxt = exec.valid & ~warm_reset;
    result_nxt       = result_r;
    if (exec.valid) begin
      result_nxt = dst_stat ? status_nxt : alu_res;
    end
  end

  // one-cycle strobe, data held until next instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_r       <= 8'h00;
      result_valid_r <= 1'b0;
    end else if (ce) begin
      result_r       <= result_nxt;
      result_valid_r <= result_valid_nxt;
    end
  end

  assign result       = result_r;
  assign result_valid = result_valid_r;

  // ---------------------------------------------------------------
  // interrupt status and mask
  // ---------------------------------------------------------------
  logic [status_pkg::EV_W-1:0] ev;         // events this cycle
  logic [status_pkg::EV_W-1:0] istat_r;    // sticky event bits
  logic [status_pkg::EV_W-1:0] istat_nxt;
  logic [status_pkg::EV_W-1:0] imask_r;    // enables
  logic [status_pkg::EV_W-1:0] imask_nxt;
  logic                        irq_r;      // interrupt level
  logic                        irq_nxt;

  // clear by writing one; a new event wins over its clear
  always_comb begin
    ev = '0;
    ev[status_pkg::EV_WDT]   = wdt_timeout;
    ev[status_pkg::EV_DOZE]  = exec.valid & exec.doze;
    ev[status_pkg::EV_BLOCK] = blocked;
    istat_nxt = istat_r;
    imask_nxt = imask_r;
    if (wr_acc && hit_istat && wr_lane0) begin
      istat_nxt = istat_r & ~pwdata[status_pkg::EV_W-1:0];
    end
    if (wr_acc && hit_imask && wr_lane0) begin
      imask_nxt = pwdata[status_pkg::EV_W-1:0];
    end
    istat_nxt = istat_nxt | ev;
    irq_nxt   = |(istat_nxt & imask_nxt);
  end

  // irq registered so it lines up with the sticky bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_r <= '0;
      imask_r <= '0;
      irq_r   <= 1'b0;
    end else if (ce) begin
      istat_r <= istat_nxt;
      imask_r <= imask_nxt;
      irq_r   <= irq_nxt;
    end
  end

  assign irq = irq_r;

  // ---------------------------------------------------------------
  // apb read data
  // ---------------------------------------------------------------
  logic [31:0] prdata_r;   // captured in setup
  logic [31:0] prdata_nxt;
  logic        pslverr_r;  // unmapped address
  logic        pslverr_nxt;

  // data captured in setup so the access phase drives a flop
  always_comb begin
    prdata_nxt  = prdata_r;
    pslverr_nxt = pslverr_r;
    if (setup) begin
      pslverr_nxt = ~hit_any;
      prdata_nxt  = 32'h0000_0000;
      if (!pwrite) begin
        if (hit_stat) begin
          prdata_nxt[7:0] = status_r & status_pkg::STATUS_IMPL;
        end else if (hit_istat) begin
          prdata_nxt[status_pkg::EV_W-1:0] = istat_r;
        end else if (hit_imask) begin
          prdata_nxt[status_pkg::EV_W-1:0] = imask_r;
        end else begin
          prdata_nxt = 32'h0000_0000;
        end
      end
    end
  end

  // holds across the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (ce) begin
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pslverr = pslverr_r & psel & penable;

endmodule // alu_status_flags

//--- hw/status_pkg.sv
// Overview of operation
// - status register writable by any instruction
// - flag-setting ops override written arithmetic flags
// - reset-cause bits ignore all writes
// - bits seven to five read zero
// - time-out bit set by power-up, clear-watchdog, doze
// - watchdog time-out clears time-out bit
// - sleep bit set by power-up, clear-watchdog
// - doze instruction clears sleep bit
// - zero flag reflects zero result
// - nibble flag is carry from bit three
// - msb flag is carry from bit seven
// - subtract adds two's complement, carries mean no-borrow
// - rotates load msb flag with shifted-out bit
// - status visible at same location every bank
package status_pkg;

  // status field positions
  localparam int FLD_C  = 0;
  localparam int FLD_DC = 1;
  localparam int FLD_Z  = 2;
  localparam int FLD_PD = 3;
  localparam int FLD_TO = 4;

  // value after power-on or brown-out
  localparam logic [7:0] STATUS_RST = 8'h18;
  // implemented bits, upper three read zero
  localparam logic [7:0] STATUS_IMPL = 8'h1f;
  // bits that an instruction may write
  localparam logic [7:0] STATUS_WMASK = 8'h07;

  // register indices, byte address is four times index
  localparam logic [13:0] STATUS_IDX   = 14'h0203;
  localparam logic [13:0] IRQ_STAT_IDX = 14'h1000;
  localparam logic [13:0] IRQ_MASK_IDX = 14'h1001;
  // banked data space spans 0x000..0xfff, 0x80 per bank
  localparam logic [13:0] BANK_SPACE   = 14'h1000;

  // interrupt event bit positions
  localparam int EV_WDT   = 0;
  localparam int EV_DOZE  = 1;
  localparam int EV_BLOCK = 2;
  localparam int EV_W     = 3;

  // operations presented by the execution datapath
  typedef enum logic [3:0] {
    OP_NONE, OP_ADD_REG, OP_ADD_IMM, OP_SUB_REG, OP_SUB_IMM,
    OP_AND, OP_IOR, OP_XOR, OP_ZERO_REG, OP_ROT_R, OP_ROT_L,
    OP_BIT_CLR, OP_BIT_SET, OP_SWAP, OP_MOVE_W, OP_WDT_CLR
  } op_e;

  // one executed instruction
  typedef struct packed {
    logic        valid;     // instruction retires this cycle
    op_e         op;        // operation
    logic        doze;      // doze instruction retires
    logic [7:0]  w;         // working register
    logic [7:0]  f;         // file operand or literal
    logic [2:0]  bit_sel;   // bit for set/clear
    logic        to_file;   // result goes to file, not w
    logic [11:0] dst_addr;  // full data address of destination
  } exec_s;

  // arithmetic flags with "affected" marks
  typedef struct packed {
    logic z;
    logic dc;
    logic c;
  } flags_s;

  // bank-independent status location
  function automatic logic is_status_loc(input logic [11:0] a);
    return a[6:0] == STATUS_IDX[6:0];
  endfunction

endpackage

//--- tb/alu_status_flags_props.sv
`timescale 1ns/1ns
// port checks for the status flag block
module alu_status_flags_props #(
  parameter int ADDR_W = 16  // apb byte address width
) (
  // clock, reset, enable
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              ce,
  // apb view
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              pslverr,
  input wire logic              pready,
  // datapath and events
  input wire status_pkg::exec_s exec,
  input wire logic [7:0]        status,
  input wire logic              wdt_timeout,
  input wire logic              warm_reset
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // expected sums; subtract adds inverted w plus one
  logic [8:0] add9;
  logic [8:0] sub9;
  logic [4:0] addn;
  logic [4:0] subn;
  logic       rbit;   // bit pushed out by a rotate
  logic       take;   // instruction retires, no warm reset
  logic       cause;  // anything allowed to move the cause bits
  always_comb begin
    add9 = {1'b0, exec.w} + {1'b0, exec.f};
    addn = {1'b0, exec.w[3:0]} + {1'b0, exec.f[3:0]};
    sub9 = {1'b0, exec.f} + {1'b0, ~exec.w} + 9'h001;
    subn = {1'b0, exec.f[3:0]} + {1'b0, ~exec.w[3:0]} + 5'h01;
    rbit = (exec.op == status_pkg::OP_ROT_R) ? exec.f[0] : exec.f[7];
    take = ce && exec.valid && !warm_reset;
    cause = ce && (wdt_timeout || warm_reset || exec.valid &&
      (exec.op == status_pkg::OP_WDT_CLR || exec.doze));
  end

  // instruction classes
  sequence s_add;
    take && (exec.op == status_pkg::OP_ADD_REG ||
      exec.op == status_pkg::OP_ADD_IMM);
  endsequence
  sequence s_sub;
    take && (exec.op == status_pkg::OP_SUB_REG ||
      exec.op == status_pkg::OP_SUB_IMM);
  endsequence
  sequence s_rot;
    take && (exec.op == status_pkg::OP_ROT_R ||
      exec.op == status_pkg::OP_ROT_L);
  endsequence

  a_upper_zero: assert property (
    status[7:5] == 3'h0) else $error("upper status bits not zero");
  a_add_flags: assert property (
    s_add |=> status[2:0] == {$past(add9[7:0]) == 8'h00,
      $past(addn[4]), $past(add9[8])}) else $error("add flags wrong");
  a_sub_flags: assert property (
    s_sub |=> status[2:0] == {$past(sub9[7:0]) == 8'h00,
      $past(subn[4]), $past(sub9[8])}) else $error("sub flags wrong");
  a_rot_carry: assert property (
    s_rot |=> status[0] == $past(rbit)) else $error("rotate carry wrong");
  a_move_write: assert property (
    take && exec.op == status_pkg::OP_MOVE_W && exec.to_file &&
    exec.dst_addr[6:0] == 7'h03 |=> status[2:0] == $past(exec.w[2:0]))
    else $error("status write lost");
  a_wdt_clears: assert property (
    ce && wdt_timeout && !warm_reset |=> !status[4])
    else $error("time-out bit not cleared");
  a_watchdog_clear_op_sets: assert property (
    take && exec.op == status_pkg::OP_WDT_CLR && !wdt_timeout
    |=> status[4:3] == 2'b11) else $error("clear-watchdog cause wrong");
  a_doze_cause: assert property (
    take && exec.doze && !wdt_timeout |=> status[4:3] == 2'b10)
    else $error("doze cause bits wrong");
  a_cause_hold: assert property (
    !cause |=> $stable(status[4:3])) else $error("cause bits moved");
  a_bank_mirror: assert property (
    psel && penable && ce && pready && paddr[ADDR_W-1:14] == '0
    |-> pslverr == (paddr[8:2] != 7'h03)) else $error("mirror decode wrong");
endmodule // alu_status_flags_props

//--- tb/alu_status_flags_tb_top.sv
`timescale 1ns/1ns
// bench for the core status flag block
module alu_status_flags_tb_top;
  // clock, reset, apb
  logic              pclk, presetn, ce, psel, penable, pwrite;
  logic [15:0]       paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [3:0]        pstrb;
  logic              pready, pslverr, result_valid, irq, er;
  // datapath and events
  status_pkg::exec_s exec;
  logic [7:0]        result, status;
  logic              wdt_timeout, warm_reset, warm_reset_wdt;
  int                n_mismatch, samples_checked;
  // arithmetic table: op, w, f, result, status
  status_pkg::op_e   top[12] = '{status_pkg::OP_ADD_REG,
    status_pkg::OP_ADD_IMM, status_pkg::OP_SUB_REG, status_pkg::OP_SUB_IMM,
    status_pkg::OP_AND, status_pkg::OP_ROT_R, status_pkg::OP_ROT_L,
    status_pkg::OP_IOR, status_pkg::OP_XOR, status_pkg::OP_SWAP,
    status_pkg::OP_BIT_SET, status_pkg::OP_BIT_CLR};
  logic [7:0] tw[12] = '{8'h0f, 8'hff, 8'h01, 8'h02, 8'hf0, 8'h00, 8'h00,
    8'h01, 8'h5a, 8'h00, 8'h03, 8'h07};
  logic [7:0] tf[12] = '{8'h01, 8'h01, 8'h10, 8'h01, 8'h0f, 8'h01, 8'h00,
    8'h00, 8'h5a, 8'h12, 8'h00, 8'hff};
  logic [7:0] tr[12] = '{8'h10, 8'h00, 8'h0f, 8'hff, 8'h00, 8'h00, 8'h01,
    8'h01, 8'h00, 8'h21, 8'h08, 8'h7f};
  logic [7:0] ts[12] = '{8'h1a, 8'h1f, 8'h19, 8'h18, 8'h1c, 8'h1d, 8'h1c,
    8'h18, 8'h1c, 8'h1c, 8'h1c, 8'h1c};

  alu_status_flags #(.ADDR_W(16)) alu_status_flags_i (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .exec(exec), .result(result), .result_valid(result_valid),
    .status(status), .wdt_timeout(wdt_timeout), .warm_reset(warm_reset),
    .warm_reset_wdt(warm_reset_wdt), .irq(irq));
  exec_model exec_model_i (.pclk(pclk), .exec(exec));

  // 4 ns clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // compare and count
  task automatic check(input string nm, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  // status once the edge has landed
  task automatic chk_st(input logic [7:0] e);
    @(negedge pclk);
    check("status", {24'h0, status}, {24'h0, e});
  endtask

  // irq is registered on the same edge as the event flags
  task automatic chk_irq(input logic e);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    check("irq", {31'h0, irq}, {31'h0, e});
  endtask

  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [15:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one-cycle hardware event pulse
  task automatic ev(input logic wd, input logic wr, input logic wc);
    @(posedge pclk);
    wdt_timeout <= wd;
    warm_reset <= wr;
    warm_reset_wdt <= wc;
    @(posedge pclk);
    wdt_timeout <= 1'b0;
    warm_reset <= 1'b0;
    warm_reset_wdt <= 1'b0;
  endtask

  // counts, verdict, stop
  task automatic complete_run;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // hang guard, far beyond the sequence length
  initial begin
    repeat (4000) @(posedge pclk);
    n_mismatch++;
    complete_run;
  end

  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, wdt_timeout} = '0;
    {warm_reset, warm_reset_wdt, paddr, pwdata} = '0;
    {n_mismatch, samples_checked} = '0;
    ce = 1'b1;
    pstrb = 4'hf;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk_st(8'h18);
    apb(1'b0, 16'h080c, 32'h0);
    check("rd", rd, 32'h0000_0018);
    for (int i = 0; i < 12; i++) begin
      exec_model_i.issue(top[i], tw[i], tf[i], 1'b0, 1'b1, 12'h020);
      chk_st(ts[i]);
      check("valid", {31'h0, result_valid}, 32'h0000_0001);
      check("res", {24'h0, result}, {24'h0, tr[i]});
    end
    // status as destination, two banks
    exec_model_i.issue(status_pkg::OP_MOVE_W, 8'h03, 8'h00, 1'b0, 1'b1,
                       12'h283);
    chk_st(8'h1b);
    exec_model_i.issue(status_pkg::OP_ZERO_REG, 8'h00, 8'h1b, 1'b0, 1'b1,
                       12'h103);
    chk_st(8'h1f);
    apb(1'b1, 16'h000c, 32'h0000_00e0);
    chk_st(8'h18);
    // disabled low byte lane leaves status untouched
    @(posedge pclk);
    pstrb <= 4'h0;
    apb(1'b1, 16'h000c, 32'h0000_0007);
    pstrb <= 4'hf;
    chk_st(8'h18);
    apb(1'b0, 16'h020c, 32'h0);
    check("rd", rd, 32'h0000_0018);
    // blocked write raised an event, still masked
    apb(1'b0, 16'h4000, 32'h0);
    check("istat", rd, 32'h0000_0004);
    chk_irq(1'b0);
    apb(1'b1, 16'h4004, 32'h0000_0007);
    chk_irq(1'b1);
    apb(1'b1, 16'h4000, 32'h0000_0004);
    chk_irq(1'b0);
    // watchdog, clear, doze
    ev(1'b1, 1'b0, 1'b0);
    chk_st(8'h08);
    chk_irq(1'b1);
    apb(1'b1, 16'h4000, 32'h0000_0001);
    chk_irq(1'b0);
    exec_model_i.issue(status_pkg::OP_WDT_CLR, 8'h0, 8'h0, 1'b0, 1'b0,
                       12'h020);
    chk_st(8'h18);
    exec_model_i.issue(status_pkg::OP_NONE, 8'h0, 8'h0, 1'b1, 1'b0,
                       12'h020);
    chk_st(8'h10);
    chk_irq(1'b1);
    apb(1'b1, 16'h4000, 32'h0000_0002);
    // unmapped place refused
    apb(1'b0, 16'h5000, 32'h0);
    check("err", {31'h0, er}, 32'h0000_0001);
    check("rd", rd, 32'h0000_0000);
    // clock enable low freezes state
    @(posedge pclk);
    ce <= 1'b0;
    exec_model_i.issue(status_pkg::OP_ADD_REG, 8'hff, 8'h01, 1'b0, 1'b0,
                       12'h020);
    chk_st(8'h10);
    check("valid", {31'h0, result_valid}, 32'h0000_0000);
    @(posedge pclk);
    ce <= 1'b1;
    // warm resets keep flags, power-on restores
    exec_model_i.issue(status_pkg::OP_MOVE_W, 8'h05, 8'h00, 1'b0, 1'b1,
                       12'h003);
    chk_st(8'h15);
    ev(1'b0, 1'b1, 1'b1);
    chk_st(8'h05);
    ev(1'b0, 1'b1, 1'b0);
    chk_st(8'h05);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    chk_st(8'h18);
    complete_run;
  end
endmodule // alu_status_flags_tb_top

bind alu_status_flags alu_status_flags_props #(.ADDR_W(ADDR_W)) props_i (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .paddr(paddr), .pslverr(pslverr), .pready(pready),
  .exec(exec), .status(status), .wdt_timeout(wdt_timeout),
  .warm_reset(warm_reset));

//--- tb/exec_model.sv
`timescale 1ns/1ns
// stands in for the core datapath issuing instructions
module exec_model (
  // clock
  input  wire logic         pclk,
  // instruction towards the flag block
  output status_pkg::exec_s exec
);
  initial exec = '0;

  // one instruction for one cycle; software picks flag-neutral ops
  // for status writes unless a test means otherwise
  task automatic issue(input status_pkg::op_e op, input logic [7:0] w,
                       input logic [7:0] f, input logic dz, input logic tf,
                       input logic [11:0] dst);
    status_pkg::exec_s t;
    @(posedge pclk);
    // bit number for set/clear rides in the low bits of w
    exec <= '{valid: 1'b1, op: op, doze: dz, w: w, f: f, bit_sel: w[2:0],
              to_file: tf, dst_addr: dst};
    @(posedge pclk);
    // idle fields scrambled so no stale operand looks valid
    t = ~exec;
    t.valid = 1'b0;
    t.doze = 1'b0;
    exec <= t;
  endtask
endmodule // exec_model
